// File: hw/fb_exchange_params.svh
// offsets, widths, reset values and timing counts for the exchange block
`ifndef FB_EXCHANGE_PARAMS_SVH
`define FB_EXCHANGE_PARAMS_SVH
`define ADDR_LINK_STATE    12'h000
`define ADDR_MASTER_NUM    12'h004
`define ADDR_OFFSET_HIGH   12'h008
`define ADDR_OFFSET_LOW    12'h00C
`define ADDR_OUT_COUNT     12'h010
`define ADDR_IN_COUNT      12'h014
`define ADDR_EXCH_CTRL     12'h018
`define ADDR_MEM_ADDR      12'h01C
`define ADDR_MEM_DATA      12'h020
`define MEM_DEPTH          256
`define MEM_AW             8
`define MAX_BUF            64
`define DEF_OFFSET         16'h0000
`define DEF_COUNT          8'h00
`define DEF_MASTER         8'h00
`define MASTER_MAX         8'h7E
`define BLINK_HALF_NS      250000000
`define CLK_PERIOD_NS      100
`define BLINK_HALF_CYC     (`BLINK_HALF_NS / `CLK_PERIOD_NS)
`define LS_IDLE            2'b00
`define LS_ERROR           2'b01
`define LS_EXCH            2'b10
`define LS_DROPPED         2'b11
`endif

// File: hw/fb_exchange_pkg.sv
// types shared by the exchange block
package fb_exchange_pkg;
  typedef enum logic [1:0] {
    IND_OFF,
    IND_GREEN,
    IND_RED,
    IND_RED_BLINK
  } indicator_t;
  typedef enum logic [1:0] {
    XF_IDLE,
    XF_WRITE_OUT,
    XF_READ_IN
  } xfer_state_t;
endpackage

// File: hw/blink_divider.sv
// half-period enable divider for the blinking indicator
`timescale 1ns/1ps
`include "fb_exchange_params.svh"
module blink_divider #(
  parameter int unsigned HALF_CYC = `BLINK_HALF_CYC
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  output logic      phase_o
);
  logic [31:0] count_reg;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= 32'h0000_0000;
      phase_o   <= 1'b0;
    end else if (!run_i) begin
      count_reg <= 32'h0000_0000;
      phase_o   <= 1'b0;
    end else if (count_reg >= HALF_CYC - 1) begin
      count_reg <= 32'h0000_0000;
      phase_o   <= ~phase_o;
    end else begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end
endmodule

// File: hw/fieldbus_slave_exchange_status.sv
// fieldbus slave data exchange, status bytes and link indicator
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "fb_exchange_params.svh"
module fieldbus_slave_exchange_status #(
  parameter int unsigned BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cfg_valid_i,
  input  wire logic        cfg_error_i,
  input  wire logic [7:0]  cfg_master_i,
  input  wire logic [15:0] cfg_offset_i,
  input  wire logic [7:0]  cfg_out_count_i,
  input  wire logic [7:0]  cfg_in_count_i,
  input  wire logic        comm_lost_i,
  input  wire logic        out_valid_i,
  input  wire logic [7:0]  out_index_i,
  input  wire logic [7:0]  out_data_i,
  input  wire logic        exch_req_i,
  input  wire logic [7:0]  in_index_i,
  output logic [7:0]       in_data_o,
  output logic             exch_done_o,
  output logic             data_exchange_o,
  output logic             green_o,
  output logic             red_o
);
  logic [1:0]  link_state_reg;
  logic [7:0]  master_num_reg;
  logic [15:0] offset_reg;
  logic [7:0]  out_count_reg;
  logic [7:0]  in_count_reg;
  logic [7:0]  vmem_reg [`MEM_DEPTH];
  logic [7:0]  pend_reg [`MAX_BUF];
  logic [7:0]  hold_reg [`MAX_BUF];
  logic        pend_new_reg;
  logic        scan_end_reg;
  logic [7:0]  mem_addr_reg;
  logic [6:0]  xf_idx_reg;
  fb_exchange_pkg::xfer_state_t xf_state_reg;
  fb_exchange_pkg::indicator_t  ind_reg;
  logic        blink_phase;
  logic        apb_access;
  logic        apb_wr;
  logic [7:0]  in_base;
  logic [7:0]  out_base;

  assign apb_access = psel && penable;
  assign apb_wr     = apb_access && pwrite;
  // outputs at low byte of offset; zero when unplaced
  assign out_base   = offset_reg[7:0];
  assign in_base    = out_base + out_count_reg;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_state_reg <= `LS_IDLE;
    end else if (cfg_valid_i) begin
      // error keeps slave out of exchange
      link_state_reg <= cfg_error_i ? `LS_ERROR : `LS_EXCH;
    end else if (comm_lost_i && link_state_reg == `LS_EXCH) begin
      link_state_reg <= `LS_DROPPED;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      master_num_reg <= `DEF_MASTER;
      offset_reg     <= `DEF_OFFSET;
      out_count_reg  <= `DEF_COUNT;
      in_count_reg   <= `DEF_COUNT;
    end else if (cfg_valid_i) begin
      // station number clipped to legal range
      master_num_reg <= (cfg_master_i > `MASTER_MAX) ? `MASTER_MAX : cfg_master_i;
      // offset kept as a word, split on read
      offset_reg     <= cfg_offset_i;
      out_count_reg  <= (cfg_out_count_i > `MAX_BUF) ? 8'(`MAX_BUF) : cfg_out_count_i;
      in_count_reg   <= (cfg_in_count_i > `MAX_BUF) ? 8'(`MAX_BUF) : cfg_in_count_i;
    end
  end

  // pending master outputs; new data flag set wins over clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_new_reg <= 1'b0;
    end else if (out_valid_i && link_state_reg == `LS_EXCH) begin
      pend_new_reg <= 1'b1;
    end else if (xf_state_reg == fb_exchange_pkg::XF_WRITE_OUT
                 && xf_idx_reg + 7'h01 >= 7'(out_count_reg)) begin
      pend_new_reg <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `MAX_BUF; g++) begin : g_pend
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          pend_reg[g] <= 8'h00;
        end else if (out_valid_i && link_state_reg == `LS_EXCH && out_index_i == 8'(g)) begin
          pend_reg[g] <= out_data_i;
        end
      end
    end
  endgenerate

  // scan-end strobe written by local software
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scan_end_reg <= 1'b0;
    end else begin
      scan_end_reg <= apb_wr && paddr == `ADDR_EXCH_CTRL && pwdata[0];
    end
  end

  // transfer sequencer run at end of user program
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      xf_state_reg <= fb_exchange_pkg::XF_IDLE;
      xf_idx_reg   <= 7'h00;
    end else begin
      case (xf_state_reg)
        fb_exchange_pkg::XF_IDLE: begin
          xf_idx_reg <= 7'h00;
          // only at scan end; outputs written only when new
          if (scan_end_reg && link_state_reg == `LS_EXCH) begin
            if (pend_new_reg && out_count_reg != 8'h00) begin
              xf_state_reg <= fb_exchange_pkg::XF_WRITE_OUT;
            end else if (in_count_reg != 8'h00) begin
              xf_state_reg <= fb_exchange_pkg::XF_READ_IN;
            end
          end
        end
        fb_exchange_pkg::XF_WRITE_OUT: begin
          if (xf_idx_reg + 7'h01 >= 7'(out_count_reg)) begin
            xf_idx_reg   <= 7'h00;
            xf_state_reg <= (in_count_reg != 8'h00) ? fb_exchange_pkg::XF_READ_IN
                                                    : fb_exchange_pkg::XF_IDLE;
          end else begin
            xf_idx_reg <= xf_idx_reg + 7'h01;
          end
        end
        fb_exchange_pkg::XF_READ_IN: begin
          if (xf_idx_reg + 7'h01 >= 7'(in_count_reg)) begin
            xf_idx_reg   <= 7'h00;
            xf_state_reg <= fb_exchange_pkg::XF_IDLE;
          end else begin
            xf_idx_reg <= xf_idx_reg + 7'h01;
          end
        end
        default: begin
          xf_state_reg <= fb_exchange_pkg::XF_IDLE;
          xf_idx_reg   <= 7'h00;
        end
      endcase
    end
  end

  // variable store: sequencer writes outputs, software writes via data port
  generate
    for (g = 0; g < `MEM_DEPTH; g++) begin : g_vmem
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          vmem_reg[g] <= 8'h00;
        end else if (xf_state_reg == fb_exchange_pkg::XF_WRITE_OUT
                     && out_base + 8'(xf_idx_reg) == 8'(g)) begin
          vmem_reg[g] <= pend_reg[xf_idx_reg[5:0]];
        end else if (apb_wr && paddr == `ADDR_MEM_DATA && mem_addr_reg == 8'(g)) begin
          vmem_reg[g] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // capture input buffer into holding store
  generate
    for (g = 0; g < `MAX_BUF; g++) begin : g_hold
      always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
          hold_reg[g] <= 8'h00;
        end else if (xf_state_reg == fb_exchange_pkg::XF_READ_IN && xf_idx_reg == 7'(g)) begin
          hold_reg[g] <= vmem_reg[in_base + 8'(g)];
        end
      end
    end
  endgenerate

  // reply built from holding store on next exchange
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      in_data_o   <= 8'h00;
      exch_done_o <= 1'b0;
    end else begin
      exch_done_o <= exch_req_i && link_state_reg == `LS_EXCH;
      if (exch_req_i && link_state_reg == `LS_EXCH) begin
        in_data_o <= (in_index_i < in_count_reg) ? hold_reg[in_index_i[5:0]] : 8'h00;
      end
    end
  end

  // software memory address pointer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_addr_reg <= 8'h00;
    end else if (apb_wr && paddr == `ADDR_MEM_ADDR) begin
      mem_addr_reg <= pwdata[7:0];
    end
  end

  // APB slave, one wait-free access phase
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        case (paddr)
          `ADDR_LINK_STATE:  prdata <= {30'h0, link_state_reg};
          `ADDR_MASTER_NUM:  prdata <= {24'h0, master_num_reg};
          `ADDR_OFFSET_HIGH: prdata <= {24'h0, offset_reg[15:8]};
          `ADDR_OFFSET_LOW:  prdata <= {24'h0, offset_reg[7:0]};
          `ADDR_OUT_COUNT:   prdata <= {24'h0, out_count_reg};
          `ADDR_IN_COUNT:    prdata <= {24'h0, in_count_reg};
          `ADDR_EXCH_CTRL:   prdata <= {31'h0, xf_state_reg != fb_exchange_pkg::XF_IDLE};
          `ADDR_MEM_ADDR:    prdata <= {24'h0, mem_addr_reg};
          `ADDR_MEM_DATA:    prdata <= {24'h0, vmem_reg[mem_addr_reg]};
          default:           pslverr <= 1'b1;
        endcase
        // status bytes are read-only, writes refused
        if (pwrite && paddr <= `ADDR_IN_COUNT) begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // indicator mode follows link state
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ind_reg <= fb_exchange_pkg::IND_OFF;
    end else begin
      case (link_state_reg)
        `LS_IDLE:  ind_reg <= fb_exchange_pkg::IND_OFF;
        `LS_ERROR: ind_reg <= fb_exchange_pkg::IND_RED_BLINK;
        `LS_EXCH:  ind_reg <= fb_exchange_pkg::IND_GREEN;
        default:   ind_reg <= fb_exchange_pkg::IND_RED;
      endcase
    end
  end

  blink_divider #(
    .HALF_CYC (BLINK_HALF_CYC)
  ) u_blink (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .run_i     (ind_reg == fb_exchange_pkg::IND_RED_BLINK),
    .phase_o   (blink_phase)
  );

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      green_o         <= 1'b0;
      red_o           <= 1'b0;
      data_exchange_o <= 1'b0;
    end else begin
      green_o         <= ind_reg == fb_exchange_pkg::IND_GREEN;
      red_o           <= ind_reg == fb_exchange_pkg::IND_RED
                         || (ind_reg == fb_exchange_pkg::IND_RED_BLINK && !blink_phase);
      data_exchange_o <= link_state_reg == `LS_EXCH;
    end
  end
endmodule

// File: tb/fb_exchange_properties.sv
// port assertions for the exchange block
`timescale 1ns/1ps
module fb_exchange_checker (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cfg_valid_i,
  input wire logic        cfg_error_i,
  input wire logic        comm_lost_i,
  input wire logic        exch_req_i,
  input wire logic        exch_done_o,
  input wire logic        data_exchange_o,
  input wire logic        green_o,
  input wire logic        red_o
);
  logic seen_reg;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_reg <= 1'b0;
    end else if (cfg_valid_i) begin
      seen_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (
    setup_s |=> answer_s) else $error("apb answer late");
  a_status_refused: assert property (
    setup_s ##0 (pwrite && paddr <= 12'h014) |=> pslverr) else $error("status write taken");
  a_cfg_exch: assert property (
    cfg_valid_i && !cfg_error_i |-> ##[1:3] data_exchange_o) else $error("no exchange");
  a_cfg_error: assert property (
    cfg_valid_i && cfg_error_i |-> ##3 !data_exchange_o && !green_o) else $error("bad cfg ran");
  a_green_steady: assert property (
    data_exchange_o && $past(data_exchange_o) |-> green_o && !red_o) else $error("not green");
  a_dark_first: assert property (
    !seen_reg |-> !green_o && !red_o) else $error("lit early");
  a_reply_given: assert property (
    exch_req_i && data_exchange_o |=> exch_done_o) else $error("no reply");
  a_lost_red: assert property (
    comm_lost_i && data_exchange_o |-> ##[2:4] red_o && !green_o) else $error("no red");
endmodule
bind fieldbus_slave_exchange_status fb_exchange_checker u_chk (
  .sys_clk_i, .rst_i, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .cfg_valid_i,
  .cfg_error_i, .comm_lost_i, .exch_req_i, .exch_done_o, .data_exchange_o, .green_o, .red_o
);

// File: tb/fb_master_model.sv
// far-side bus master: configuration, output bytes, reply requests
`timescale 1ns/1ps
module fb_master_model (
  input  wire logic        sys_clk_i,
  input  wire logic [7:0]  in_data_i,
  input  wire logic        exch_done_i,
  output logic             cfg_valid_o = 1'b0,
  output logic             cfg_error_o = 1'b0,
  output logic [7:0]       cfg_master_o = 8'h00,
  output logic [15:0]      cfg_offset_o = 16'h0000,
  output logic [7:0]       cfg_out_count_o = 8'h00,
  output logic [7:0]       cfg_in_count_o = 8'h00,
  output logic             comm_lost_o = 1'b0,
  output logic             out_valid_o = 1'b0,
  output logic [7:0]       out_index_o = 8'h00,
  output logic [7:0]       out_data_o = 8'h00,
  output logic             exch_req_o = 1'b0,
  output logic [7:0]       in_index_o = 8'h00
);
  task automatic configure(input logic [7:0] m, input logic [15:0] o, input logic [7:0] oc,
                           input logic [7:0] ic, input logic e);
    @(posedge sys_clk_i);
    cfg_valid_o     <= 1'b1;
    cfg_error_o     <= e;
    cfg_master_o    <= m;
    cfg_offset_o    <= o;
    cfg_out_count_o <= oc;
    cfg_in_count_o  <= ic;
    @(posedge sys_clk_i);
    cfg_valid_o     <= 1'b0;
    // stale fields inverted so nothing leans on them
    cfg_error_o     <= ~e;
    cfg_master_o    <= ~m;
    cfg_offset_o    <= ~o;
    cfg_out_count_o <= ~oc;
    cfg_in_count_o  <= ~ic;
  endtask
  task automatic lose();
    @(posedge sys_clk_i);
    comm_lost_o <= 1'b1;
    @(posedge sys_clk_i);
    comm_lost_o <= 1'b0;
  endtask
  task automatic send(input logic [7:0] i, input logic [7:0] d);
    @(posedge sys_clk_i);
    out_valid_o <= 1'b1;
    out_index_o <= i;
    out_data_o  <= d;
    @(posedge sys_clk_i);
    out_valid_o <= 1'b0;
    out_index_o <= ~i;
    out_data_o  <= ~d;
  endtask
  // one reply per exchange; gap makes it slow
  task automatic ask(input logic [7:0] i, input int gap, output logic [7:0] d, output logic ok);
    repeat (gap) @(posedge sys_clk_i);
    @(posedge sys_clk_i);
    exch_req_o <= 1'b1;
    in_index_o <= i;
    @(posedge sys_clk_i);
    exch_req_o <= 1'b0;
    in_index_o <= ~i;
    @(posedge sys_clk_i);
    d  = in_data_i;
    ok = exch_done_i;
  endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench for the exchange block
`timescale 1ns/1ps
`include "fb_exchange_params.svh"
module tb_top;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, cfg_valid_i, cfg_error_i, comm_lost_i, out_valid_i;
  logic        exch_req_i, exch_done_o, data_exchange_o, green_o, red_o, ok;
  logic [7:0]  cfg_master_i, cfg_out_count_i, cfg_in_count_i, out_index_i, out_data_i;
  logic [7:0]  in_index_i, in_data_o, d;
  logic [15:0] cfg_offset_i;
  logic [31:0] seed = 32'h0000_000B;
  int          bad_count = 0;
  int          check_count = 0;
  int          mem [256];
  int          hold [64];
  int          pend [64];
  int          oc, ic, fresh, n;
  always #50 sys_clk_i = ~sys_clk_i;
  fieldbus_slave_exchange_status #(.BLINK_HALF_CYC(4)) u_dut (.sys_clk_i, .rst_i, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cfg_valid_i, .cfg_error_i,
    .cfg_master_i, .cfg_offset_i, .cfg_out_count_i, .cfg_in_count_i, .comm_lost_i, .out_valid_i,
    .out_index_i, .out_data_i, .exch_req_i, .in_index_i, .in_data_o, .exch_done_o,
    .data_exchange_o, .green_o, .red_o);
  fb_master_model u_master (.sys_clk_i, .in_data_i(in_data_o), .exch_done_i(exch_done_o),
    .cfg_valid_o(cfg_valid_i), .cfg_error_o(cfg_error_i), .cfg_master_o(cfg_master_i),
    .cfg_offset_o(cfg_offset_i), .cfg_out_count_o(cfg_out_count_i),
    .cfg_in_count_o(cfg_in_count_i), .comm_lost_o(comm_lost_i), .out_valid_o(out_valid_i),
    .out_index_o(out_index_i), .out_data_o(out_data_i), .exch_req_o(exch_req_i),
    .in_index_o(in_index_i));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed & 32'h0000_00FF;
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input int a, input int wd, output logic [31:0] q,
                     output logic e);
    int k;
    @(posedge sys_clk_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= 12'(a);
    pwdata <= 32'(wd);
    @(posedge sys_clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      bad_count++;
      give_verdict();
    end
  endtask
  task automatic rchk(input int a, input int x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 0, q, e);
    check($sformatf("reg %h", a), q, x);
  endtask
  task automatic wchk(input int a, input int wd, input logic x);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, wd, q, e);
    check($sformatf("slverr %h", a), 32'(e), 32'(x));
  endtask
  task automatic mput(input int a, input int v);
    mem[a] = v;
    wchk(`ADDR_MEM_ADDR, a, 1'b0);
    wchk(`ADDR_MEM_DATA, v, 1'b0);
  endtask
  task automatic mchk(input int a);
    wchk(`ADDR_MEM_ADDR, a, 1'b0);
    rchk(`ADDR_MEM_DATA, mem[a]);
  endtask
  task automatic stat(input int x [6]);
    for (int i = 0; i < 6; i++)
      rchk(4 * i, x[i]);
  endtask
  task automatic scan();
    logic [31:0] q;
    logic        e;
    int          k;
    wchk(`ADDR_EXCH_CTRL, 1, 1'b0);
    k = 0;
    do begin
      apb(1'b0, `ADDR_EXCH_CTRL, 0, q, e);
      k++;
    end while (q[0] !== 1'b0 && k < 100);
    if (q[0] !== 1'b0) begin
      bad_count++;
      give_verdict();
    end
    for (int i = 0; i < oc && fresh; i++)
      mem[48 + i] = pend[i];
    fresh = 0;
    for (int i = 0; i < ic; i++)
      hold[i] = mem[48 + oc + i];
  endtask
  task automatic reply(input int i, input int gap);
    u_master.ask(8'(i), gap, d, ok);
    check("reply", 32'(d), i < ic ? hold[i] : 0);
    check("done", 32'(ok), 1);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    stat('{0, 0, 0, 0, 0, 0});
    check("lamp", {green_o, red_o}, 0);
    wchk(12'h030, 0, 1'b1);
    wchk(`ADDR_OFFSET_HIGH, 8'h55, 1'b1);
    rchk(`ADDR_OFFSET_HIGH, 0);
    u_master.configure(8'h05, 16'h0130, 8'h04, 8'h04, 1'b1);
    repeat (6) @(posedge sys_clk_i);
    stat('{1, 5, 1, 48, 4, 4});
    n = 0;
    repeat (16) begin
      @(posedge sys_clk_i);
      n += red_o;
    end
    check("blink", n, 8);
    check("lamp", {green_o, data_exchange_o}, 0);
    u_master.configure(8'h7E, 16'h0030, 8'h04, 8'h03, 1'b0);
    oc = 4;
    ic = 3;
    repeat (4) @(posedge sys_clk_i);
    stat('{2, 126, 0, 48, 4, 3});
    check("lamp", {green_o, red_o}, 2);
    wchk(`ADDR_OUT_COUNT, 8'h3F, 1'b1);
    rchk(`ADDR_OUT_COUNT, 4);
    for (int i = 0; i < 7; i++)
      mput(48 + i, xs());
    for (int i = 0; i < 4; i++) begin
      pend[i] = xs();
      u_master.send(8'(i), 8'(pend[i]));
    end
    fresh = 1;
    mchk(48);
    scan();
    for (int i = 0; i < 7; i++)
      mchk(48 + i);
    for (int i = 0; i < 4; i++)
      reply(i, i);
    mput(48, 8'hA5);
    mput(52, 8'h5A);
    reply(0, 0);
    scan();
    mchk(48);
    reply(0, 3);
    u_master.lose();
    u_master.send(8'h00, 8'h3C);
    rchk(`ADDR_LINK_STATE, 3);
    repeat (8) @(posedge sys_clk_i);
    check("lamp", {green_o, red_o}, 1);
    // out-of-range station number must be clipped
    u_master.configure(8'hC8, 16'h0030, 8'h04, 8'h03, 1'b0);
    repeat (4) @(posedge sys_clk_i);
    rchk(`ADDR_LINK_STATE, 2);
    rchk(`ADDR_MASTER_NUM, 126);
    check("lamp", {green_o, red_o}, 2);
    scan();
    mchk(48);
    // bad config mid-exchange, then a loss that must not leave the error state
    u_master.configure(8'h05, 16'h0030, 8'h04, 8'h03, 1'b1);
    u_master.lose();
    repeat (4) @(posedge sys_clk_i);
    rchk(`ADDR_LINK_STATE, 1);
    check("lamp", {green_o, data_exchange_o}, 0);
    give_verdict();
  end
endmodule
